/* File: pkg/csie_pkg.sv */
// constants shared by the clock-system interrupt-enable register bank
package csie_pkg;

    localparam int unsigned CSIE_ADDR_W = 12;
    localparam int unsigned CSIE_DATA_W = 32;
    localparam int unsigned CSIE_STRB_W = CSIE_DATA_W / 8;
    localparam int unsigned CSIE_WORD_LSB = 2;

    // register byte offsets
    localparam logic [CSIE_ADDR_W-1:0] CSIE_OFF_IE_CLEAR   = 12'h000;
    localparam logic [CSIE_ADDR_W-1:0] CSIE_OFF_IE_SET     = 12'h004;
    localparam logic [CSIE_ADDR_W-1:0] CSIE_OFF_EVT_STATUS = 12'h008;
    localparam logic [CSIE_ADDR_W-1:0] CSIE_OFF_EVT_MASK   = 12'h00c;
    localparam logic [CSIE_ADDR_W-1:0] CSIE_OFF_IRQ_FLAG   = 12'h010;
    localparam logic [CSIE_ADDR_W-1:0] CSIE_OFF_IRQ_REQ    = 12'h014;

    // enable bit positions, same in set and clear views
    localparam int unsigned CSIE_BIT_PLL_LOCK_TIMEOUT   = 17;
    localparam int unsigned CSIE_BIT_PLL_LOCK_FALL      = 16;
    localparam int unsigned CSIE_BIT_PLL_LOCK_RISE      = 15;
    localparam int unsigned CSIE_BIT_BROWNOUT_SYNC_RDY  = 11;
    localparam int unsigned CSIE_BIT_BROWNOUT_DETECT    = 10;
    localparam int unsigned CSIE_BIT_BROWNOUT_READY     = 9;
    localparam int unsigned CSIE_BIT_FLL_REF_CLK_STOP   = 8;
    localparam int unsigned CSIE_BIT_FLL_LOCK_COARSE    = 7;
    localparam int unsigned CSIE_BIT_FLL_LOCK_FINE      = 6;
    localparam int unsigned CSIE_BIT_FLL_OUT_OF_BOUNDS  = 5;
    localparam int unsigned CSIE_BIT_FLL_READY          = 4;
    localparam int unsigned CSIE_BIT_INT_8M_OSC_READY   = 3;
    localparam int unsigned CSIE_BIT_INT_32K_OSC_READY  = 2;
    localparam int unsigned CSIE_BIT_EXT_32K_OSC_READY  = 1;
    localparam int unsigned CSIE_BIT_EXT_XTAL_OSC_READY = 0;

    localparam logic [CSIE_DATA_W-1:0] CSIE_ONE = 32'h0000_0001;

    // implemented enable positions; all others are reserved
    localparam logic [CSIE_DATA_W-1:0] CSIE_IE_VALID =
        (CSIE_ONE << CSIE_BIT_PLL_LOCK_TIMEOUT)  | (CSIE_ONE << CSIE_BIT_PLL_LOCK_FALL)     |
        (CSIE_ONE << CSIE_BIT_PLL_LOCK_RISE)     | (CSIE_ONE << CSIE_BIT_BROWNOUT_SYNC_RDY) |
        (CSIE_ONE << CSIE_BIT_BROWNOUT_DETECT)   | (CSIE_ONE << CSIE_BIT_BROWNOUT_READY)    |
        (CSIE_ONE << CSIE_BIT_FLL_REF_CLK_STOP)  | (CSIE_ONE << CSIE_BIT_FLL_LOCK_COARSE)   |
        (CSIE_ONE << CSIE_BIT_FLL_LOCK_FINE)     | (CSIE_ONE << CSIE_BIT_FLL_OUT_OF_BOUNDS) |
        (CSIE_ONE << CSIE_BIT_FLL_READY)         | (CSIE_ONE << CSIE_BIT_INT_8M_OSC_READY)  |
        (CSIE_ONE << CSIE_BIT_INT_32K_OSC_READY) | (CSIE_ONE << CSIE_BIT_EXT_32K_OSC_READY) |
        (CSIE_ONE << CSIE_BIT_EXT_XTAL_OSC_READY);

    localparam logic [CSIE_DATA_W-1:0] CSIE_RST_ENABLE = 32'h0000_0000;
    localparam logic [CSIE_DATA_W-1:0] CSIE_RST_STATUS = 32'h0000_0000;
    localparam logic [CSIE_DATA_W-1:0] CSIE_RST_MASK   = 32'h0000_0000;
    localparam logic [CSIE_DATA_W-1:0] CSIE_ZERO       = 32'h0000_0000;

    localparam logic [1:0] CSIE_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CSIE_RESP_SLVERR = 2'h2;

endpackage

/* File: hdl/csie_axil_slave.sv */
// axi4-lite slave front end: handshakes, one write and one read in flight
`timescale 1ns/1ps
module csie_axil_slave (
    input  wire logic                                clk,
    input  wire logic                                reset_n,
    input  wire logic [csie_pkg::CSIE_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    input  wire logic [csie_pkg::CSIE_DATA_W-1:0]    s_axi_wdata,
    input  wire logic [csie_pkg::CSIE_STRB_W-1:0]    s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    input  wire logic [csie_pkg::CSIE_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    output logic [csie_pkg::CSIE_DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    output logic                                     wr_fire,
    output logic [csie_pkg::CSIE_ADDR_W-1:0]         wr_addr,
    output logic [csie_pkg::CSIE_DATA_W-1:0]         wr_data,
    output logic [csie_pkg::CSIE_STRB_W-1:0]         wr_strb,
    input  wire logic                                wr_err,
    output logic                                     rd_fire,
    output logic [csie_pkg::CSIE_ADDR_W-1:0]         rd_addr,
    input  wire logic [csie_pkg::CSIE_DATA_W-1:0]    rd_data,
    input  wire logic                                rd_err
);
    import csie_pkg::*;

    logic                   aw_have_ff, nxt_aw_have;
    logic                   w_have_ff,  nxt_w_have;
    logic [CSIE_ADDR_W-1:0] awaddr_ff,  nxt_awaddr;
    logic [CSIE_DATA_W-1:0] wdata_ff,   nxt_wdata;
    logic [CSIE_STRB_W-1:0] wstrb_ff,   nxt_wstrb;
    logic                   awready_ff, nxt_awready;
    logic                   wready_ff,  nxt_wready;
    logic                   bvalid_ff,  nxt_bvalid;
    logic [1:0]             bresp_ff,   nxt_bresp;
    logic                   arready_ff, nxt_arready;
    logic                   rvalid_ff,  nxt_rvalid;
    logic [CSIE_DATA_W-1:0] rdata_ff,   nxt_rdata;
    logic [1:0]             rresp_ff,   nxt_rresp;
    logic                   aw_hs, w_hs;

    assign s_axi_awready = awready_ff;
    assign s_axi_wready  = wready_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    // write path: address and data may arrive in either order
    always_comb begin
        aw_hs       = s_axi_awvalid & awready_ff;
        w_hs        = s_axi_wvalid & wready_ff;
        nxt_awaddr  = aw_hs ? s_axi_awaddr : awaddr_ff;
        nxt_wdata   = w_hs ? s_axi_wdata : wdata_ff;
        nxt_wstrb   = w_hs ? s_axi_wstrb : wstrb_ff;
        nxt_aw_have = aw_have_ff | aw_hs;
        nxt_w_have  = w_have_ff | w_hs;
        nxt_bvalid  = bvalid_ff & ~s_axi_bready;
        nxt_bresp   = bresp_ff;
        wr_fire     = nxt_aw_have & nxt_w_have & ~bvalid_ff;
        wr_addr     = nxt_awaddr;
        wr_data     = nxt_wdata;
        wr_strb     = nxt_wstrb;
        if (wr_fire) begin
            nxt_aw_have = 1'b0;
            nxt_w_have  = 1'b0;
            nxt_bvalid  = 1'b1;
            nxt_bresp   = wr_err ? CSIE_RESP_SLVERR : CSIE_RESP_OKAY;
        end
        // hold off new items until the response has gone
        nxt_awready = ~nxt_aw_have & ~nxt_bvalid;
        nxt_wready  = ~nxt_w_have & ~nxt_bvalid;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            awaddr_ff  <= '0;
            wdata_ff   <= CSIE_ZERO;
            wstrb_ff   <= '0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= CSIE_RESP_OKAY;
        end else begin
            aw_have_ff <= nxt_aw_have;
            w_have_ff  <= nxt_w_have;
            awaddr_ff  <= nxt_awaddr;
            wdata_ff   <= nxt_wdata;
            wstrb_ff   <= nxt_wstrb;
            awready_ff <= nxt_awready;
            wready_ff  <= nxt_wready;
            bvalid_ff  <= nxt_bvalid;
            bresp_ff   <= nxt_bresp;
        end
    end

    // read path: data is captured at the address handshake
    always_comb begin
        rd_fire     = s_axi_arvalid & arready_ff;
        rd_addr     = s_axi_araddr;
        nxt_rvalid  = rvalid_ff & ~s_axi_rready;
        nxt_rdata   = rdata_ff;
        nxt_rresp   = rresp_ff;
        if (rd_fire) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = rd_data;
            nxt_rresp  = rd_err ? CSIE_RESP_SLVERR : CSIE_RESP_OKAY;
        end
        nxt_arready = ~nxt_rvalid;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= CSIE_ZERO;
            rresp_ff   <= CSIE_RESP_OKAY;
        end else begin
            arready_ff <= nxt_arready;
            rvalid_ff  <= nxt_rvalid;
            rdata_ff   <= nxt_rdata;
            rresp_ff   <= nxt_rresp;
        end
    end

endmodule

/* File: hdl/csie_core.sv */
// clock-system interrupt-enable bank with set/clear views and event interrupt
`timescale 1ns/1ps
// Function
// (R1) writing zero to any enable bit, set or clear view, changes nothing
// (R2) writing one to a clear-view bit drops that interrupt enable
// (R3) writing one to a set-view bit raises that interrupt enable
// (R4) request asserted only while enable is one and flag is set; irq_req is registered and follows them one cycle late
// (R5) set view at 0x04, resets to zero, writes blocked under write protection
// (R6) bits 17, 16, 15: pll lock timeout, lock fall, lock rise
// (R7) bits 6, 5, 4: fll lock fine, out of bounds, ready
// (R8) bits 3..0: 8m osc, int 32k osc, ext 32k osc, crystal ready
// (R9) bits 11..7: brownout sync ready, detect, ready, fll ref stop, coarse lock
// (R10) clear view also clears bits 17 through 0, same layout as set view
// (R11) both views share one enable vector; reserved bits read zero
module csie_core (
    input  wire logic                                clk,
    input  wire logic                                reset_n,
    input  wire logic [csie_pkg::CSIE_ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                                s_axi_awvalid,
    output logic                                     s_axi_awready,
    input  wire logic [csie_pkg::CSIE_DATA_W-1:0]    s_axi_wdata,
    input  wire logic [csie_pkg::CSIE_STRB_W-1:0]    s_axi_wstrb,
    input  wire logic                                s_axi_wvalid,
    output logic                                     s_axi_wready,
    output logic [1:0]                               s_axi_bresp,
    output logic                                     s_axi_bvalid,
    input  wire logic                                s_axi_bready,
    input  wire logic [csie_pkg::CSIE_ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                                s_axi_arvalid,
    output logic                                     s_axi_arready,
    output logic [csie_pkg::CSIE_DATA_W-1:0]         s_axi_rdata,
    output logic [1:0]                               s_axi_rresp,
    output logic                                     s_axi_rvalid,
    input  wire logic                                s_axi_rready,
    input  wire logic [csie_pkg::CSIE_DATA_W-1:0]    irq_flag,
    input  wire logic                                wp_active,
    output logic [csie_pkg::CSIE_DATA_W-1:0]         irq_req,
    output logic                                     irq
);
    import csie_pkg::*;

    // bus-side strobes from the front end
    logic                   wr_fire;
    logic [CSIE_ADDR_W-1:0] wr_addr;
    logic [CSIE_DATA_W-1:0] wr_data;
    logic [CSIE_STRB_W-1:0] wr_strb;
    logic                   wr_err;
    logic                   rd_fire;
    logic [CSIE_ADDR_W-1:0] rd_addr;
    logic [CSIE_DATA_W-1:0] rd_data;
    logic                   rd_err;

    // register state
    logic [CSIE_DATA_W-1:0] enable_ff,  nxt_enable;
    logic [CSIE_DATA_W-1:0] req_ff,     nxt_req;
    logic [CSIE_DATA_W-1:0] status_ff,  nxt_status;
    logic [CSIE_DATA_W-1:0] mask_ff,    nxt_mask;
    logic                   irq_ff,     nxt_irq;

    // decoded write intent
    logic                   wr_ie_clear;
    logic                   wr_ie_set;
    logic                   wr_mask;
    logic [CSIE_DATA_W-1:0] wr_bits;
    logic                   rd_status;
    logic [CSIE_DATA_W-1:0] req_rise;

    // word compare ignoring the byte-within-word bits
    function automatic logic csie_hit(
        input logic [CSIE_ADDR_W-1:0] addr,
        input logic [CSIE_ADDR_W-1:0] offset
    );
        csie_hit = (addr[CSIE_ADDR_W-1:CSIE_WORD_LSB] == offset[CSIE_ADDR_W-1:CSIE_WORD_LSB]);
    endfunction

    // byte enables widened to a bit mask
    function automatic logic [CSIE_DATA_W-1:0] csie_lanes(
        input logic [CSIE_STRB_W-1:0] strb
    );
        logic [CSIE_DATA_W-1:0] m;
        m = CSIE_ZERO;
        for (int i = 0; i < CSIE_STRB_W; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        csie_lanes = m;
    endfunction

    // only implemented enable positions ever take a value
    function automatic logic [CSIE_DATA_W-1:0] csie_valid(
        input logic [CSIE_DATA_W-1:0] v
    );
        csie_valid = v & CSIE_IE_VALID;
    endfunction

    csie_axil_slave u_slave (
        .clk           (clk),
        .reset_n       (reset_n),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .wr_fire       (wr_fire),
        .wr_addr       (wr_addr),
        .wr_data       (wr_data),
        .wr_strb       (wr_strb),
        .wr_err        (wr_err),
        .rd_fire       (rd_fire),
        .rd_addr       (rd_addr),
        .rd_data       (rd_data),
        .rd_err        (rd_err)
    );

    // write decode
    always_comb begin
        wr_bits     = csie_valid(wr_data & csie_lanes(wr_strb));  // R11
        wr_ie_clear = 1'b0;
        wr_ie_set   = 1'b0;
        wr_mask     = 1'b0;
        wr_err      = 1'b0;
        if (wr_fire) begin
            if (csie_hit(wr_addr, CSIE_OFF_IE_CLEAR)) begin
                // protected writes are refused so software can see them fail
                wr_ie_clear = ~wp_active;
                wr_err      = wp_active;
            end else if (csie_hit(wr_addr, CSIE_OFF_IE_SET)) begin
                wr_ie_set = ~wp_active;  // R5
                wr_err    = wp_active;   // R5
            end else if (csie_hit(wr_addr, CSIE_OFF_EVT_MASK)) begin
                wr_mask = 1'b1;
            end else if (csie_hit(wr_addr, CSIE_OFF_EVT_STATUS) ||
                         csie_hit(wr_addr, CSIE_OFF_IRQ_FLAG) ||
                         csie_hit(wr_addr, CSIE_OFF_IRQ_REQ)) begin
                wr_err = 1'b0;  // read-only views ignore writes, answer okay
            end else begin
                wr_err = 1'b1;
            end
        end
    end

    // read decode; both enable views return the one shared vector
    always_comb begin
        rd_data   = CSIE_ZERO;
        rd_err    = 1'b0;
        rd_status = 1'b0;
        if (csie_hit(rd_addr, CSIE_OFF_IE_CLEAR) || csie_hit(rd_addr, CSIE_OFF_IE_SET)) begin
            rd_data = enable_ff;  // R11
        end else if (csie_hit(rd_addr, CSIE_OFF_EVT_STATUS)) begin
            rd_data   = status_ff;
            rd_status = rd_fire;
        end else if (csie_hit(rd_addr, CSIE_OFF_EVT_MASK)) begin
            rd_data = mask_ff;
        end else if (csie_hit(rd_addr, CSIE_OFF_IRQ_FLAG)) begin
            rd_data = csie_valid(irq_flag);
        end else if (csie_hit(rd_addr, CSIE_OFF_IRQ_REQ)) begin
            rd_data = req_ff;
        end else begin
            rd_err = 1'b1;
        end
    end

    // shared enable vector; zero bits in either view leave it alone
    always_comb begin
        nxt_enable = enable_ff;
        if (wr_ie_clear) begin
            nxt_enable = enable_ff & ~wr_bits;  // R1 R2 R6 R7 R8 R9 R10
        end
        if (wr_ie_set) begin
            nxt_enable = enable_ff | wr_bits;   // R1 R3 R6 R7 R8 R9
        end
        nxt_enable = csie_valid(nxt_enable);    // R11
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            enable_ff <= CSIE_RST_ENABLE;  // R5
        end else begin
            enable_ff <= nxt_enable;
        end
    end

    // per-source request from flag and enable
    always_comb begin
        nxt_req  = csie_valid(irq_flag) & enable_ff;  // R4
        req_rise = nxt_req & ~req_ff;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            req_ff <= CSIE_ZERO;
        end else begin
            req_ff <= nxt_req;
        end
    end

    // sticky event status; a new request edge beats a clearing read
    always_comb begin
        nxt_status = status_ff;
        if (rd_status) begin
            nxt_status = CSIE_ZERO;
        end
        nxt_status = nxt_status | req_rise;
        nxt_mask   = mask_ff;
        if (wr_mask) begin
            nxt_mask = csie_valid((mask_ff & ~csie_lanes(wr_strb)) | (wr_data & csie_lanes(wr_strb)));
        end
        nxt_irq = |(nxt_status & nxt_mask);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            status_ff <= CSIE_RST_STATUS;
            mask_ff   <= CSIE_RST_MASK;
            irq_ff    <= 1'b0;
        end else begin
            status_ff <= nxt_status;
            mask_ff   <= nxt_mask;
            irq_ff    <= nxt_irq;
        end
    end

    assign irq_req = req_ff;
    assign irq     = irq_ff;

endmodule

/* File: sim/csie_chk.sv */
// concurrent checks on the ports of the interrupt-enable register bank
`timescale 1ns/1ps
module csie_chk
    import csie_pkg::*;
(
    input wire logic                             clk,
    input wire logic                             reset_n,
    input wire logic [csie_pkg::CSIE_ADDR_W-1:0] s_axi_awaddr,
    input wire logic                             s_axi_awvalid,
    input wire logic                             s_axi_awready,
    input wire logic                             s_axi_wvalid,
    input wire logic                             s_axi_wready,
    input wire logic [1:0]                       s_axi_bresp,
    input wire logic                             s_axi_bvalid,
    input wire logic                             s_axi_bready,
    input wire logic [csie_pkg::CSIE_ADDR_W-1:0] s_axi_araddr,
    input wire logic                             s_axi_arvalid,
    input wire logic                             s_axi_arready,
    input wire logic [csie_pkg::CSIE_DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0]                       s_axi_rresp,
    input wire logic                             s_axi_rvalid,
    input wire logic                             s_axi_rready,
    input wire logic [csie_pkg::CSIE_DATA_W-1:0] irq_flag,
    input wire logic                             wp_active,
    input wire logic [csie_pkg::CSIE_DATA_W-1:0] irq_req
);
    logic wr_hs;
    logic rd_hs;

    assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    assign rd_hs = s_axi_arvalid && s_axi_arready;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_req_needs_flag: assert property ((irq_req & ~$past(irq_flag)) == CSIE_ZERO)
        else $error("request without its flag");
    a_req_resv_zero: assert property ((irq_req & ~CSIE_IE_VALID) == CSIE_ZERO)
        else $error("request on a reserved position");
    a_wr_answer: assert property (wr_hs |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write not answered next cycle");
    a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rd_answer: assert property (rd_hs |=> s_axi_rvalid && !s_axi_arready)
        else $error("read not answered next cycle");
    a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_wp_refused: assert property (wr_hs && wp_active && s_axi_awaddr[11:3] == 9'h0
        |=> s_axi_bresp == CSIE_RESP_SLVERR) else $error("protected write not refused");
    a_rd_unmapped: assert property (rd_hs && s_axi_araddr >= 12'h018
        |=> s_axi_rresp == CSIE_RESP_SLVERR && s_axi_rdata == CSIE_ZERO) else $error("unmapped read answered");
    a_en_resv_read: assert property (rd_hs && s_axi_araddr[11:3] == 9'h0
        |=> (s_axi_rdata & ~CSIE_IE_VALID) == CSIE_ZERO) else $error("reserved enable bit reads one");
endmodule

bind csie_core csie_chk u_chk (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .irq_flag(irq_flag), .wp_active(wp_active), .irq_req(irq_req)
);

/* File: sim/clock_sys_irq_enable_set_clear_test.sv */
// self-checking bench for the interrupt-enable register bank
`timescale 1ns/1ps
module clock_sys_irq_enable_set_clear_test;
    import csie_pkg::*;
    // implemented enables: 17..15 and 11..0
    localparam logic [31:0] EXP_VALID = 32'h0003_8fff;
    logic        clk = 1'h0, reset_n = 1'h0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, irq_flag = 32'h0, s_axi_rdata, irq_req, en, d, fl, rv;
    logic [3:0]  s_axi_wstrb = 4'h0, st;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, wp_active = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, side;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
    int          mismatches = 0, comparisons = 0, cycles = 0, seed = 73;

    csie_core dut (
        .clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .irq_flag(irq_flag), .wp_active(wp_active), .irq_req(irq_req), .irq(irq)
    );

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // starts one edge late so bready/rready never get two drives in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    // unstrobed lanes count as written zeros
    function automatic logic [31:0] next_en(input logic [31:0] e, input logic set, input logic [31:0] v,
                                            input logic [3:0] s);
        logic [31:0] m;
        m = v & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & EXP_VALID;
        return set ? (e | m) : (e & ~m);
    endfunction

    initial begin
        en = 32'h0;
        repeat (4) @(posedge clk);
        reset_n <= 1'h1;
        rd(CSIE_OFF_IE_SET, rv, rs);
        check("set view after reset", 32'h0, rv);
        check("set view resp", {30'h0, CSIE_RESP_OKAY}, {30'h0, rs});
        rd(CSIE_OFF_IE_CLEAR, rv, rs);
        check("clear view after reset", 32'h0, rv);
        @(posedge clk);
        irq_flag <= 32'hffff_ffff;
        for (int b = 0; b < 32; b++) begin
            d = 32'h1 << b;
            wr(CSIE_OFF_IE_SET, d, 4'hf, rs);
            check("set resp", {30'h0, CSIE_RESP_OKAY}, {30'h0, rs});
            rd(CSIE_OFF_IE_CLEAR, rv, rs);
            check("bit walk set", d & EXP_VALID, rv);
            check("bit walk request", d & EXP_VALID, irq_req);
            wr(CSIE_OFF_IE_CLEAR, d, 4'hf, rs);
            rd(CSIE_OFF_IE_SET, rv, rs);
            check("bit walk clear", 32'h0, rv);
        end
        for (int i = 0; i < 40; i++) begin
            d = $random(seed);
            st = 4'($random(seed));
            side = 1'($random(seed));
            fl = $random(seed);
            @(posedge clk);
            irq_flag <= fl;
            wr(side ? CSIE_OFF_IE_SET : CSIE_OFF_IE_CLEAR, d, st, rs);
            en = next_en(en, side, d, st);
            rd(side ? CSIE_OFF_IE_CLEAR : CSIE_OFF_IE_SET, rv, rs);
            check("random enables", en, rv);
            check("random request", fl & en, irq_req);
        end
        @(posedge clk);
        wp_active <= 1'h1;
        wr(CSIE_OFF_IE_SET, 32'hffff_ffff, 4'hf, rs);
        check("protected set resp", {30'h0, CSIE_RESP_SLVERR}, {30'h0, rs});
        wr(CSIE_OFF_IE_CLEAR, 32'hffff_ffff, 4'hf, rs);
        check("protected clear resp", {30'h0, CSIE_RESP_SLVERR}, {30'h0, rs});
        rd(CSIE_OFF_IE_SET, rv, rs);
        check("protected enables", en, rv);
        wp_active <= 1'h0;
        wr(12'h100, 32'hffff_ffff, 4'hf, rs);
        check("unmapped write resp", {30'h0, CSIE_RESP_SLVERR}, {30'h0, rs});
        rd(12'h100, rv, rs);
        check("unmapped read data", 32'h0, rv);
        check("unmapped read resp", {30'h0, CSIE_RESP_SLVERR}, {30'h0, rs});
        wr(CSIE_OFF_IRQ_FLAG, 32'hffff_ffff, 4'hf, rs);
        check("read-only write resp", {30'h0, CSIE_RESP_OKAY}, {30'h0, rs});
        irq_flag <= 32'h0;
        wr(CSIE_OFF_IE_CLEAR, 32'hffff_ffff, 4'hf, rs);
        wr(CSIE_OFF_EVT_MASK, 32'h0, 4'hf, rs);
        wr(CSIE_OFF_IE_SET, 32'h10, 4'hf, rs);
        rd(CSIE_OFF_EVT_STATUS, rv, rs);
        @(posedge clk);
        irq_flag <= 32'h10;
        repeat (3) @(posedge clk);
        check("masked irq", 32'h0, {31'h0, irq});
        wr(CSIE_OFF_EVT_MASK, 32'h10, 4'hf, rs);
        check("unmasked irq", 32'h1, {31'h0, irq});
        rd(CSIE_OFF_EVT_STATUS, rv, rs);
        check("event status", 32'h10, rv);
        check("irq after status read", 32'h0, {31'h0, irq});
        rd(CSIE_OFF_IRQ_REQ, rv, rs);
        check("request view", 32'h10, rv);
        rd(CSIE_OFF_IRQ_FLAG, rv, rs);
        check("flag view", 32'h10, rv);
        give_verdict();
    end
endmodule
